// [rtl/ddrio_pkg.sv]
// shared constants and types for the ddr memory i/o data path
package ddrio_pkg;
    // pin counts: eight data bytes, one extra line per byte, nine strobe groups
    localparam int DQ_W = 72;
    localparam int BYTE_W = 8;
    localparam int NUM_BYTES = 8;
    localparam int EXTRA_BASE = 64;
    localparam int NUM_GRP = 9;
    localparam int CHECK_GRP = 8;
    localparam int ADDR_W = 16;
    localparam int CMD_W = 4;
    // read fifo between capture clock and system clock
    localparam int FIFO_AW = 2;
    localparam int FIFO_DEPTH = 4;
    // burst length code that qdr ii operation refuses
    localparam logic [1:0] BURST_TWO = 2'h0;
    // memory clock halves for the ddr output pair
    localparam logic CK_RISE_HALF = 1'h1;
    localparam logic CK_FALL_HALF = 1'h0;
    // reset values
    localparam logic [DQ_W-1:0] DQ_RST = 72'h0;
    localparam logic [NUM_GRP-1:0] GRP_RST = 9'h0;
    localparam logic [NUM_GRP-1:0] DM_RST = 9'h1ff;
    // bus width modes, gray coded from narrow to wide
    typedef enum logic [2:0] {
        DDRIO_X8 = 3'h0,
        DDRIO_X9 = 3'h1,
        DDRIO_X16 = 3'h3,
        DDRIO_X18 = 3'h2,
        DDRIO_X32 = 3'h6,
        DDRIO_X36 = 3'h7,
        DDRIO_X72 = 3'h5
    } ddrio_mode_e;
endpackage

// [rtl/ddrio_capture.sv]
// double-rate read capture, alignment and synchronising registers per data line
`timescale 1ns/1ps
`default_nettype none
module ddrio_capture #(
    parameter int W = 72
) (
    // capture clock and reset
    input wire logic cap_clk,
    input wire logic nrst,
    // read data pins
    input wire logic [W-1:0] dq_in,
    // synchronising register contents
    output logic [W-1:0] sync_h,
    output logic [W-1:0] sync_l
);
    logic [W-1:0] rise_reg;
    logic [W-1:0] fall_reg;
    logic [W-1:0] align_reg;

    always_ff @(posedge cap_clk or negedge nrst)
    begin
        if (!nrst)
            rise_reg <= '0; // R19
        else
            rise_reg <= dq_in; // R2
    end

    always_ff @(negedge cap_clk or negedge nrst)
    begin
        if (!nrst)
            fall_reg <= '0; // R19
        else
            fall_reg <= dq_in; // R3
    end

    // rising half is held over the falling edge so both halves meet at the next rise
    always_ff @(negedge cap_clk or negedge nrst)
    begin
        if (!nrst)
            align_reg <= '0; // R19
        else
            align_reg <= rise_reg; // R4
    end

    always_ff @(posedge cap_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_h <= '0; // R19
            sync_l <= '0;
        end
        else
        begin
            sync_h <= align_reg; // R5
            sync_l <= fall_reg;
        end
    end
endmodule
`default_nettype wire

// [rtl/ddrio_datapath.sv]
// ddr memory i/o data path: read capture to system clock, write launch, command, memory clock
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: each data line gets three capture-side fabric registers beside its pin.
// R2: rising-edge register samples read data on every capture clock rise.
// R3: falling-edge register samples read data on every capture clock fall.
// R4: alignment register lines both halves up before the system clock domain.
// R5: halves pass high and low sync registers, then a fifo to system clock.
// R6: capture uses the pll capture clock, never the read strobe; no postamble.
// R7: data mask low during a write marks the data valid.
// R8: data mask high during a write makes memory ignore that data.
// R9: exactly one data mask line per strobe and data group.
// R10: data mask launched on the same -90 degree write clock as data.
// R11: x9, x18, x36 carry one parity line per byte, handled as data.
// R12: wide modes reuse narrow mode lines plus one, two or four extras.
// R13: 72-bit ecc uses 64 data and 8 check lines in their own group.
// R14: ecc encode and decode belong to the controller, not this path.
// R15: address and command change once per system clock, single rate.
// R16: qdr ii operation with burst length two is refused.
// R17: memory clock pairs come from ddr output registers like a strobe.
// R18: memory captures address and command on ck or k clock pairs.
// R19: reset clears capture, alignment, sync registers and empties the fifo.
module ddrio_datapath (
    // system clock domain
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // read capture clock from the pll
    input wire logic cap_clk,
    // write clock, -90 degrees from clk
    input wire logic wr_clk,
    // configuration
    input wire ddrio_pkg::ddrio_mode_e width_mode,
    input wire logic qdr_mode,
    input wire logic [1:0] burst_len,
    // read pins
    input wire logic [ddrio_pkg::DQ_W-1:0] dq_in,
    // read side to core
    input wire logic rd_capture,
    output logic rd_valid,
    output logic [ddrio_pkg::DQ_W-1:0] rd_data_h,
    output logic [ddrio_pkg::DQ_W-1:0] rd_data_l,
    // write side from core
    input wire logic wr_valid,
    input wire logic [ddrio_pkg::DQ_W-1:0] wr_data_h,
    input wire logic [ddrio_pkg::DQ_W-1:0] wr_data_l,
    input wire logic [ddrio_pkg::NUM_GRP-1:0] wr_byte_en_h,
    input wire logic [ddrio_pkg::NUM_GRP-1:0] wr_byte_en_l,
    // write pins, halves for the ddr output registers
    output logic [ddrio_pkg::DQ_W-1:0] dq_out_h,
    output logic [ddrio_pkg::DQ_W-1:0] dq_out_l,
    output logic [ddrio_pkg::DQ_W-1:0] dq_oe,
    output logic [ddrio_pkg::NUM_GRP-1:0] dm_out_h,
    output logic [ddrio_pkg::NUM_GRP-1:0] dm_out_l,
    // address and command from core
    input wire logic [ddrio_pkg::ADDR_W-1:0] addr_in,
    input wire logic [ddrio_pkg::CMD_W-1:0] cmd_in,
    // address and command pins
    output logic [ddrio_pkg::ADDR_W-1:0] mem_addr,
    output logic [ddrio_pkg::CMD_W-1:0] mem_cmd,
    // memory clock pair halves
    output logic mem_ck_h,
    output logic mem_ck_l,
    output logic mem_ck_n_h,
    output logic mem_ck_n_l,
    // status
    output logic cfg_err
);
    localparam int DW = ddrio_pkg::DQ_W;
    localparam int GW = ddrio_pkg::NUM_GRP;
    localparam int AW = ddrio_pkg::FIFO_AW;

    // lines in use for a width mode; extras sit above the data bytes
    function automatic logic [DW-1:0] line_mask(input ddrio_pkg::ddrio_mode_e m);
        logic [DW-1:0] mk;
        int nb;
        logic ext;
        mk = '0;
        nb = 1;
        ext = 1'b0;
        unique case (m)
            ddrio_pkg::DDRIO_X8:
            begin
                nb = 1;
            end
            ddrio_pkg::DDRIO_X9:
            begin
                nb = 1;
                ext = 1'b1; // R12
            end
            ddrio_pkg::DDRIO_X16:
            begin
                nb = 2;
            end
            ddrio_pkg::DDRIO_X18:
            begin
                nb = 2;
                ext = 1'b1; // R12
            end
            ddrio_pkg::DDRIO_X32:
            begin
                nb = 4;
            end
            ddrio_pkg::DDRIO_X36:
            begin
                nb = 4;
                ext = 1'b1; // R12
            end
            ddrio_pkg::DDRIO_X72:
            begin
                nb = ddrio_pkg::NUM_BYTES;
                ext = 1'b1; // R13
            end
            default:
            begin
                nb = 1;
            end
        endcase
        for (int b = 0; b < ddrio_pkg::NUM_BYTES; b++)
        begin
            if (b < nb)
            begin
                mk[b*ddrio_pkg::BYTE_W +: ddrio_pkg::BYTE_W] = '1;
                mk[ddrio_pkg::EXTRA_BASE + b] = ext; // R11
            end
        end
        return mk;
    endfunction

    // one mask line per strobe group; the check group only exists in x72
    function automatic logic [GW-1:0] grp_mask(input ddrio_pkg::ddrio_mode_e m);
        logic [DW-1:0] lm;
        logic [GW-1:0] gm;
        lm = line_mask(m);
        gm = '0;
        for (int g = 0; g < ddrio_pkg::NUM_BYTES; g++)
        begin
            gm[g] = lm[g*ddrio_pkg::BYTE_W]; // R9
        end
        gm[ddrio_pkg::CHECK_GRP] = (m == ddrio_pkg::DDRIO_X72); // R13
        return gm;
    endfunction

    // configuration, system domain
    ddrio_pkg::ddrio_mode_e mode_reg;
    logic [DW-1:0] lines_reg;
    logic [GW-1:0] grps_reg;
    logic bl_bad;

    assign bl_bad = qdr_mode && (burst_len == ddrio_pkg::BURST_TWO);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_reg <= ddrio_pkg::DDRIO_X8;
            lines_reg <= ddrio_pkg::DQ_RST;
            grps_reg <= ddrio_pkg::GRP_RST;
            cfg_err <= 1'b0;
        end
        else if (ce)
        begin
            mode_reg <= width_mode;
            lines_reg <= line_mask(mode_reg);
            grps_reg <= grp_mask(mode_reg);
            cfg_err <= bl_bad; // R16
        end
    end

    // read capture: the pll clock samples data, the strobe pin is not used
    logic [DW-1:0] cap_h;
    logic [DW-1:0] cap_l;

    ddrio_capture #(
        .W(DW)
    ) u_capture (
        .cap_clk(cap_clk), // R6
        .nrst(nrst),
        .dq_in(dq_in), // R1
        .sync_h(cap_h),
        .sync_l(cap_l)
    );

    // capture enable crosses into the capture domain as a level
    logic en_meta_reg;
    logic en_cap_reg;

    always_ff @(posedge cap_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            en_meta_reg <= 1'b0;
            en_cap_reg <= 1'b0;
        end
        else
        begin
            en_meta_reg <= rd_capture;
            en_cap_reg <= en_meta_reg;
        end
    end

    // read fifo with gray pointers between capture and system clocks
    logic [2*DW-1:0] fifo_mem [ddrio_pkg::FIFO_DEPTH];
    logic [AW:0] wbin_reg;
    logic [AW:0] wgray_reg;
    logic [AW:0] rbin_reg;
    logic [AW:0] rgray_reg;
    logic [AW:0] rg_meta_reg;
    logic [AW:0] rg_cap_reg;
    logic [AW:0] wg_meta_reg;
    logic [AW:0] wg_sys_reg;
    logic [AW:0] wbin_next;
    logic [AW:0] rbin_next;
    logic fifo_full;
    logic fifo_empty;
    logic fifo_push;
    logic fifo_pop;

    assign wbin_next = wbin_reg + (AW+1)'(1);
    assign rbin_next = rbin_reg + (AW+1)'(1);
    assign fifo_full = wgray_reg == {~rg_cap_reg[AW:AW-1], rg_cap_reg[AW-2:0]};
    assign fifo_empty = rgray_reg == wg_sys_reg;
    // a full fifo drops the beat; the core must drain faster than it captures
    assign fifo_push = en_cap_reg && !fifo_full;
    assign fifo_pop = ce && !fifo_empty;

    always_ff @(posedge cap_clk)
    begin
        if (fifo_push)
            fifo_mem[wbin_reg[AW-1:0]] <= {cap_h, cap_l}; // R5
    end

    always_ff @(posedge cap_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wbin_reg <= '0; // R19
            wgray_reg <= '0;
        end
        else if (fifo_push)
        begin
            wbin_reg <= wbin_next;
            wgray_reg <= wbin_next ^ (wbin_next >> 1);
        end
    end

    always_ff @(posedge cap_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rg_meta_reg <= '0;
            rg_cap_reg <= '0;
        end
        else
        begin
            rg_meta_reg <= rgray_reg;
            rg_cap_reg <= rg_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wg_meta_reg <= '0;
            wg_sys_reg <= '0;
        end
        else if (ce)
        begin
            wg_meta_reg <= wgray_reg;
            wg_sys_reg <= wg_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rbin_reg <= '0; // R19
            rgray_reg <= '0;
        end
        else if (fifo_pop)
        begin
            rbin_reg <= rbin_next;
            rgray_reg <= rbin_next ^ (rbin_next >> 1);
        end
    end

    // both halves leave on the same rising edge of the system clock
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_valid <= 1'b0;
            rd_data_h <= ddrio_pkg::DQ_RST;
            rd_data_l <= ddrio_pkg::DQ_RST;
        end
        else if (ce)
        begin
            rd_valid <= fifo_pop;
            if (fifo_pop)
            begin
                rd_data_h <= fifo_mem[rbin_reg[AW-1:0]][2*DW-1:DW] & lines_reg; // R5
                rd_data_l <= fifo_mem[rbin_reg[AW-1:0]][DW-1:0] & lines_reg;
            end
        end
    end

    // write staging in the system domain; check lines pass through untouched
    logic [DW-1:0] st_h_reg;
    logic [DW-1:0] st_l_reg;
    logic [DW-1:0] st_oe_reg;
    logic [GW-1:0] st_dm_h_reg;
    logic [GW-1:0] st_dm_l_reg;
    logic wr_ok;

    assign wr_ok = wr_valid && !bl_bad; // R16

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_h_reg <= ddrio_pkg::DQ_RST;
            st_l_reg <= ddrio_pkg::DQ_RST;
            st_oe_reg <= ddrio_pkg::DQ_RST;
            st_dm_h_reg <= ddrio_pkg::DM_RST;
            st_dm_l_reg <= ddrio_pkg::DM_RST;
        end
        else if (ce)
        begin
            st_h_reg <= wr_data_h & lines_reg; // R14
            st_l_reg <= wr_data_l & lines_reg;
            st_oe_reg <= wr_ok ? lines_reg : ddrio_pkg::DQ_RST; // R11
            // enabled byte drives mask low, all else high
            st_dm_h_reg <= wr_ok ? ~(wr_byte_en_h & grps_reg) : ddrio_pkg::DM_RST; // R7 R8
            st_dm_l_reg <= wr_ok ? ~(wr_byte_en_l & grps_reg) : ddrio_pkg::DM_RST; // R7 R8
        end
    end

    // launch on the shifted write clock; same pll, so the path is timed, not synchronised
    always_ff @(posedge wr_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dq_out_h <= ddrio_pkg::DQ_RST;
            dq_out_l <= ddrio_pkg::DQ_RST;
            dq_oe <= ddrio_pkg::DQ_RST;
        end
        else
        begin
            dq_out_h <= st_h_reg;
            dq_out_l <= st_l_reg;
            dq_oe <= st_oe_reg;
        end
    end

    always_ff @(posedge wr_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dm_out_h <= ddrio_pkg::DM_RST;
            dm_out_l <= ddrio_pkg::DM_RST;
        end
        else
        begin
            dm_out_h <= st_dm_h_reg; // R10
            dm_out_l <= st_dm_l_reg; // R10
        end
    end

    // address and command at single rate on the system clock
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mem_addr <= '0;
            mem_cmd <= '0;
        end
        else if (ce)
        begin
            mem_addr <= addr_in; // R15
            mem_cmd <= cmd_in; // R15
        end
    end

    // memory clock pair as a strobe-like ddr pattern; memory samples command on it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mem_ck_h <= ddrio_pkg::CK_FALL_HALF;
            mem_ck_l <= ddrio_pkg::CK_FALL_HALF;
            mem_ck_n_h <= ddrio_pkg::CK_FALL_HALF;
            mem_ck_n_l <= ddrio_pkg::CK_FALL_HALF;
        end
        else if (ce)
        begin
            mem_ck_h <= ddrio_pkg::CK_RISE_HALF; // R17 R18
            mem_ck_l <= ddrio_pkg::CK_FALL_HALF; // R17
            mem_ck_n_h <= ddrio_pkg::CK_FALL_HALF; // R17
            mem_ck_n_l <= ddrio_pkg::CK_RISE_HALF; // R17
        end
    end
endmodule
`default_nettype wire

// [testbench/ddrio_sva.sv]
// assertion checker on the ports of the ddr memory i/o data path
`timescale 1ns/1ps
`default_nettype none
module ddrio_sva (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // inputs watched
    input wire logic ce,
    input wire logic qdr_mode,
    input wire logic [1:0] burst_len,
    input wire logic rd_capture,
    input wire logic [ddrio_pkg::ADDR_W-1:0] addr_in,
    input wire logic [ddrio_pkg::CMD_W-1:0] cmd_in,
    // outputs watched
    input wire logic rd_valid,
    input wire logic [ddrio_pkg::DQ_W-1:0] rd_data_h,
    input wire logic [ddrio_pkg::DQ_W-1:0] rd_data_l,
    input wire logic [ddrio_pkg::DQ_W-1:0] dq_oe,
    input wire logic [ddrio_pkg::NUM_GRP-1:0] dm_out_h,
    input wire logic [ddrio_pkg::NUM_GRP-1:0] dm_out_l,
    input wire logic [ddrio_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [ddrio_pkg::CMD_W-1:0] mem_cmd,
    input wire logic mem_ck_h,
    input wire logic mem_ck_l,
    input wire logic mem_ck_n_h,
    input wire logic mem_ck_n_l,
    input wire logic cfg_err
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // saturates well past the capture sync and fifo drain time
    logic [4:0] idle_cnt_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            idle_cnt_reg <= 5'h0;
        else if (rd_capture)
            idle_cnt_reg <= 5'h0;
        else if (idle_cnt_reg != 5'h1f)
            idle_cnt_reg <= idle_cnt_reg + 5'h1;
    end
    sequence s_refused;
        (qdr_mode && burst_len == 2'h0) [*4];
    endsequence
    sequence s_ck_run;
        mem_ck_h && !mem_ck_l && !mem_ck_n_h && mem_ck_n_l;
    endsequence
    a_cmd_follow: assert property (ce |=> mem_addr == $past(addr_in) && mem_cmd == $past(cmd_in))
        else $error("address or command not copied one cycle later");
    a_cmd_hold: assert property (!ce |=> $stable(mem_addr) && $stable(mem_cmd))
        else $error("address or command changed without clock enable");
    a_cfg_set: assert property (ce && qdr_mode && burst_len == 2'h0 |=> cfg_err)
        else $error("burst of two in qdr mode not flagged");
    a_cfg_clear: assert property (ce && !(qdr_mode && burst_len == 2'h0) |=> !cfg_err)
        else $error("configuration error flagged without cause");
    a_ck_pattern: assert property (ce |=> s_ck_run)
        else $error("memory clock halves not in strobe pattern");
    a_wr_refused: assert property (s_refused |-> !(|dq_oe) && dm_out_h == 9'h1ff)
        else $error("write driven while burst of two refused");
    a_dm_idle: assert property (!(|dq_oe) |-> dm_out_h == 9'h1ff && dm_out_l == 9'h1ff)
        else $error("data mask low while no write is driven");
    a_rd_hold: assert property (!rd_valid |-> $stable(rd_data_h) && $stable(rd_data_l))
        else $error("read data changed between beats");
    a_rd_quiet: assert property (idle_cnt_reg == 5'h1f |-> !rd_valid)
        else $error("read beat without capture request");
endmodule
`default_nettype wire

// [testbench/ddrio_mem_model.sv]
// memory-side model: double-rate read stream and masked write image
`timescale 1ns/1ps
`default_nettype none
module ddrio_mem_model (
    // clocks
    input wire logic cap_clk,
    input wire logic wr_clk,
    // read stream control
    input wire logic run,
    // write pins
    input wire logic [ddrio_pkg::DQ_W-1:0] dq_oe,
    input wire logic [ddrio_pkg::NUM_GRP-1:0] dm_out_h,
    input wire logic [ddrio_pkg::DQ_W-1:0] dq_out_h,
    // read pins and written bytes
    output logic [ddrio_pkg::DQ_W-1:0] dq_in,
    output logic [ddrio_pkg::DQ_W-1:0] img
);
    logic [7:0] beat = 8'h0;
    initial
    begin
        dq_in = 72'h0;
        img = 72'h0;
    end
    // outside a stream the lines toggle so a stale value never looks valid
    always @(negedge cap_clk)
        dq_in <= #1 run ? {9{beat}} : ~dq_in;
    always @(posedge cap_clk)
    begin
        dq_in <= #1 run ? {9{beat + 8'h1}} : ~dq_in;
        if (run)
            beat <= beat + 8'h2;
    end
    // only the high half is kept: enough to see masking work
    always @(posedge wr_clk)
        for (int g = 0; g < ddrio_pkg::NUM_BYTES; g++)
            if (dq_oe[8 * g] && !dm_out_h[g]) img[8 * g +: 8] <= dq_out_h[8 * g +: 8];
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the ddr memory i/o data path
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("[FAIL] %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_top;
    logic clk, nrst, ce, cap_clk, wr_clk, qdr_mode, rd_capture, rd_valid, wr_valid, run, cfg_err;
    logic mem_ck_h, mem_ck_l, mem_ck_n_h, mem_ck_n_l;
    logic [1:0] burst_len;
    ddrio_pkg::ddrio_mode_e width_mode;
    logic [ddrio_pkg::DQ_W-1:0] dq_in, rd_data_h, rd_data_l, wr_data_h, wr_data_l;
    logic [ddrio_pkg::DQ_W-1:0] dq_out_h, dq_out_l, dq_oe, img;
    logic [ddrio_pkg::NUM_GRP-1:0] wr_byte_en_h, wr_byte_en_l, dm_out_h, dm_out_l;
    logic [ddrio_pkg::ADDR_W-1:0] addr_in, mem_addr;
    logic [ddrio_pkg::CMD_W-1:0] cmd_in, mem_cmd;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    ddrio_pkg::ddrio_mode_e modes [7] = '{ddrio_pkg::DDRIO_X8, ddrio_pkg::DDRIO_X9,
        ddrio_pkg::DDRIO_X16, ddrio_pkg::DDRIO_X18, ddrio_pkg::DDRIO_X32,
        ddrio_pkg::DDRIO_X36, ddrio_pkg::DDRIO_X72};

    ddrio_datapath u_dut (.*);
    ddrio_mem_model u_mem (.cap_clk(cap_clk), .wr_clk(wr_clk), .run(run), .dq_oe(dq_oe),
        .dm_out_h(dm_out_h), .dq_out_h(dq_out_h), .dq_in(dq_in), .img(img));

    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        wr_clk = 1'h0;
        // first rise at 3.75 ns: a quarter period after each clk rise, so it lags by 90 degrees
        #1.25;
        forever #2.5 wr_clk = ~wr_clk;
    end
    initial
    begin
        cap_clk = 1'h0;
        #1.3;
        forever #7.5 cap_clk = ~cap_clk;
    end

    function automatic logic [71:0] mask_of(input ddrio_pkg::ddrio_mode_e m);
        case (m)
            ddrio_pkg::DDRIO_X9: return 72'h01_0000_0000_0000_00ff;
            ddrio_pkg::DDRIO_X16: return 72'hffff;
            ddrio_pkg::DDRIO_X18: return 72'h03_0000_0000_0000_ffff;
            ddrio_pkg::DDRIO_X32: return 72'hffff_ffff;
            ddrio_pkg::DDRIO_X36: return 72'h0f_0000_0000_ffff_ffff;
            ddrio_pkg::DDRIO_X72: return {72{1'b1}};
            default: return 72'hff;
        endcase
    endfunction

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic t_reset();
        nrst = 1'h0;
        repeat (10) @(posedge clk);
        #1;
        `CHK("rst_valid", 1'h0, rd_valid);
        `CHK("rst_data", 72'h0, rd_data_h);
        `CHK("rst_dm", 9'h1ff, dm_out_h);
        `CHK("rst_oe", 72'h0, dq_oe);
        nrst = 1'h1;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic t_cmd();
        addr_in = 16'ha5c3;
        cmd_in = 4'h9;
        @(posedge clk);
        #1;
        `CHK("addr", 16'ha5c3, mem_addr);
        `CHK("cmd", 4'h9, mem_cmd);
        `CHK("ck", 4'h9, ({mem_ck_h, mem_ck_l, mem_ck_n_h, mem_ck_n_l}));
        ce = 1'h0;
        addr_in = 16'h0f0f;
        repeat (2) @(posedge clk);
        #1;
        `CHK("addr_hold", 16'ha5c3, mem_addr);
        ce = 1'h1;
        @(posedge clk);
        #1;
        `CHK("addr_new", 16'h0f0f, mem_addr);
    endtask

    task automatic t_read(input ddrio_pkg::ddrio_mode_e m);
        logic [71:0] mk;
        logic [7:0] b;
        int n;
        int w;
        mk = mask_of(m);
        width_mode = m;
        run = 1'h1;
        repeat (9) @(posedge clk);
        #1;
        rd_capture = 1'h1;
        n = 0;
        w = 0;
        while (n < 6 && w < 200)
        begin
            @(posedge clk);
            #1;
            w++;
            if (rd_valid === 1'h1)
            begin
                if (n == 0)
                    b = rd_data_h[7:0];
                `CHK("rd_h", {9{b}} & mk, rd_data_h);
                `CHK("rd_l", {9{b + 8'h1}} & mk, rd_data_l);
                b = b + 8'h2;
                n++;
            end
        end
        `CHK("rd_beats", 6, n);
        rd_capture = 1'h0;
        repeat (6) @(posedge clk);
        #1;
        run = 1'h0;
        repeat (40) @(posedge clk);
        #1;
    endtask

    task automatic t_write(input ddrio_pkg::ddrio_mode_e m, input logic q, input logic [1:0] bl);
        logic [71:0] mk;
        logic [8:0] gm;
        logic ok;
        ok = !(q && bl == 2'h0);
        mk = ok ? mask_of(m) : 72'h0;
        for (int g = 0; g < 8; g++)
            gm[g] = mk[8 * g];
        gm[8] = ok && m == ddrio_pkg::DDRIO_X72;
        width_mode = m;
        qdr_mode = q;
        burst_len = bl;
        repeat (3) @(posedge clk);
        #1;
        wr_valid = 1'h1;
        @(posedge clk);
        #1;
        wr_valid = 1'h0;
        for (int k = 0; k < 4 && !(ok && |dq_oe); k++)
            @(posedge wr_clk) #0.5;
        `CHK("dq_oe", mk, dq_oe);
        if (ok)
            `CHK("dq_h", wr_data_h & mk, dq_out_h);
        if (ok)
            `CHK("dq_l", wr_data_l & mk, dq_out_l);
        `CHK("dm_h", ~(wr_byte_en_h & gm), dm_out_h);
        `CHK("dm_l", ~(wr_byte_en_l & gm), dm_out_l);
        `CHK("cfg_err", !ok, cfg_err);
        @(posedge clk);
        #1;
    endtask

    initial
    begin
        nrst = 1'h0;
        ce = 1'h1;
        qdr_mode = 1'h0;
        burst_len = 2'h1;
        width_mode = ddrio_pkg::DDRIO_X8;
        rd_capture = 1'h0;
        wr_valid = 1'h0;
        run = 1'h0;
        wr_data_h = {9{8'h3c}};
        wr_data_l = {9{8'hc3}};
        wr_byte_en_h = 9'h0a5;
        wr_byte_en_l = 9'h15a;
        addr_in = 16'h0;
        cmd_in = 4'h0;
        t_reset();
        t_cmd();
        for (int i = 0; i < 7; i++)
            t_read(modes[i]);
        for (int i = 0; i < 7; i++)
            t_write(modes[i], 1'h0, 2'h1);
        t_write(ddrio_pkg::DDRIO_X18, 1'h1, 2'h0);
        t_write(ddrio_pkg::DDRIO_X36, 1'h1, 2'h1);
        `CHK("img", 24'h3c003c, img[23:0]);
        // reset in mid-stream must still leave read valid, the high read data half and output enable cleared and the high data mask half all high
        qdr_mode = 1'h0;
        t_read(ddrio_pkg::DDRIO_X72);
        run = 1'h1;
        rd_capture = 1'h1;
        repeat (20) @(posedge clk);
        #1;
        t_reset();
        rd_capture = 1'h0;
        run = 1'h0;
        repeat (40) @(posedge clk);
        end_of_test();
    end
endmodule
bind ddrio_datapath ddrio_sva u_sva (.*);
`default_nettype wire
